// [src/motor_ctrl_pkg.sv]
// How it works
// [RULE1] advance codes 0x00-0x0f step 2.5us, 0x7f 4800us
// [RULE2] setting is 2.5us times mantissa shifted by exponent
// [RULE3] mode 0 fixed, mode 1 scaled by (U-BEMF)/U
// [RULE4] overcurrent trip always armed, level not programmable
// [RULE5] overcurrent stops drive, resumes once it clears
// [RULE6] amplitude capped at Ilim*Rph plus speed*Kt
// [RULE7] acceleration limit only closed loop, never faults
// [RULE8] six enable bits gate lock and no-motor checks
// [RULE9] enabled lock condition sets motor locked flag
// [RULE10] six cause flags, cleared when the motor restarts
// [RULE11] cause flags set even when scheme disabled
// [RULE12] lock forces phases hi-z, anti-surge on entry
// [RULE13] after lock-off wait, restart automatically
// [RULE14] low-side current over threshold acts as lock
// [RULE15] software sets lock threshold above accel limit
// [RULE16] lock-off wait is a parameterised cycle timer
// [RULE17] speed command ignored while the timer runs
package motor_ctrl_pkg;
  // clock
  localparam real CLK_PERIOD_NS = 10.0;
  // advance step of one mantissa unit
  localparam real ADV_STEP_US = 2.5;
  localparam int ADV_STEP_CYC = int'(ADV_STEP_US * 1000.0 / CLK_PERIOD_NS);
  // lock-off interval default, in ms
  localparam int LOCK_OFF_MS = 1000;
  localparam int LOCK_OFF_CYC_DEF =
    int'(real'(LOCK_OFF_MS) * 1000000.0 / CLK_PERIOD_NS);

  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MOTOR = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_ADV = 8'h14;

  // control field positions
  localparam int CTRL_ADV_LSB = 0;
  localparam int CTRL_MODE_BIT = 8;
  localparam int CTRL_ACCEL_LSB = 12;
  localparam int CTRL_LOCK_LSB = 16;
  localparam int CTRL_EN_LSB = 24;
  // motor constants field positions
  localparam int MOTOR_RM_LSB = 0;
  localparam int MOTOR_KT_LSB = 8;
  // status field positions
  localparam int STAT_LOCKED_BIT = 0;
  localparam int STAT_OC_BIT = 1;
  localparam int STAT_HIZ_BIT = 2;
  localparam int STAT_FAULT_LSB = 8;
  // interrupt bits
  localparam int IRQ_LOCK = 0;
  localparam int IRQ_OC = 1;
  localparam int IRQ_RESTART = 2;
  localparam int IRQ_W = 3;

  // reset values
  localparam logic [5:0] LOCK_EN_RST = 6'h3f;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // scaling
  localparam int LOCK_THR_SHIFT = 5;
  localparam int AMP_SHIFT = 4;
  localparam logic [8:0] AMP_MAX = 9'h1ff;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_LOCKOFF = 2'b10
  } mstate_t;
endpackage

// [src/adv_scale_div.sv]
`timescale 1ns/10ps
module adv_scale_div
  import motor_ctrl_pkg::*;
#(
  parameter int NUM_W = 20,
  parameter int DEN_W = 9
)(
  input wire logic i_clk, // system clock
  input wire logic i_nrst, // sync reset, low
  input wire logic i_ce, // clock enable
  input wire logic i_start, // begin a division
  input wire logic [NUM_W-1:0] i_num, // dividend
  input wire logic [DEN_W-1:0] i_den, // divisor, nonzero
  output logic o_busy, // division running
  output logic o_done, // quotient valid pulse
  output logic [NUM_W-1:0] o_quot // quotient
);
  localparam int CNT_W = $clog2(NUM_W + 1);

  typedef struct packed {
    logic busy;
    logic done;
    logic [CNT_W-1:0] cnt;
    logic [DEN_W:0] rem;
    logic [NUM_W-1:0] quo;
    logic [DEN_W-1:0] den;
  } div_t;

  div_t s;
  div_t next_s;

  // restoring divider, one quotient bit per cycle to save a wide array
  always_comb
  begin
    logic [DEN_W:0] rem_sh;
    rem_sh = '0;
    next_s = s;
    next_s.done = 1'b0;
    if (!s.busy && i_start)
    begin
      next_s.busy = 1'b1;
      next_s.cnt = '0;
      next_s.rem = '0;
      next_s.quo = i_num;
      next_s.den = i_den;
    end
    else if (s.busy)
    begin
      rem_sh = {s.rem[DEN_W-1:0], s.quo[NUM_W-1]};
      if (rem_sh >= {1'b0, s.den})
      begin
        next_s.rem = rem_sh - {1'b0, s.den};
        next_s.quo = {s.quo[NUM_W-2:0], 1'b1};
      end
      else
      begin
        next_s.rem = rem_sh;
        next_s.quo = {s.quo[NUM_W-2:0], 1'b0};
      end
      next_s.cnt = s.cnt + 1'b1;
      if (s.cnt == CNT_W'(NUM_W - 1))
      begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      s <= '0;
    else if (i_ce)
      s <= next_s;
  end

  assign o_busy = s.busy;
  assign o_done = s.done;
  assign o_quot = s.quo;
endmodule

// [src/motor_advance_limit_lock_ctrl.sv]
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module motor_advance_limit_lock_ctrl
  import motor_ctrl_pkg::*;
#(
  parameter int LOCK_OFF_CYC = LOCK_OFF_CYC_DEF,
  parameter int TIMER_W = 32
)(
  input wire logic I_REF_CLK, // 100 MHz system clock
  input wire logic I_NRST, // sync reset, low
  input wire logic I_CE, // clock enable
  input wire logic [7:0] I_ADDR, // register byte address
  input wire logic [31:0] I_WDATA, // write data
  input wire logic I_WR, // write strobe
  input wire logic I_RD, // read strobe
  input wire logic I_OC_PIN, // overcurrent comparator pin
  input wire logic [7:0] I_LS_CURRENT, // low-side current sample
  input wire logic [5:1] I_LOCK_DET, // lock/no-motor detectors
  input wire logic I_CLOSED_LOOP, // closed-loop operation
  input wire logic [8:0] I_SPEED_CMD, // commanded amplitude
  input wire logic [9:0] I_SPEED_HZ, // electrical speed
  input wire logic [8:0] I_BEMF_AMP, // estimated bemf amplitude
  output logic [31:0] O_RDATA, // read data, cycle after strobe
  output logic [8:0] O_DRIVE_AMP, // applied amplitude
  output logic O_PHASE_HIZ, // all phases high impedance
  output logic O_AVS_START, // anti-surge start pulse
  output logic O_LOCKED, // motor locked flag
  output logic [5:0] O_FAULT_CAUSE, // cause flags
  output logic [18:0] O_ADV_CYCLES, // advance time in clocks
  output logic O_IRQ // level interrupt
);
  typedef struct packed {
    mstate_t st;
    logic oc_meta;
    logic oc_sync;
    logic [6:0] adv_set;
    logic adv_mode;
    logic [3:0] accel_sel;
    logic [2:0] lock_sel;
    logic [5:0] lock_en;
    logic [6:0] rm;
    logic [6:0] kt;
    logic locked;
    logic [5:0] fault;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic [TIMER_W-1:0] timer;
    logic [8:0] drive;
    logic hiz;
    logic anti_surge_process;
    logic [10:0] adv_units;
    logic [18:0] adv_cyc;
    logic div_start;
    logic [31:0] rdata;
  } ctrl_t;

  ctrl_t s;
  ctrl_t next_s;

  logic div_busy;
  logic div_done;
  logic [19:0] div_quot;
  logic [19:0] div_num;

  // advance setting in 2.5us units: mantissa shifted by exponent
  function automatic logic [10:0] adv_decode(input logic [6:0] code);
    adv_decode = {7'h00, code[3:0]} << code[6:4]; // [RULE1] [RULE2]
  endfunction

  // lock current threshold in sample units, 3-bit select
  function automatic logic [8:0] lock_thr(input logic [2:0] sel);
    lock_thr = ({6'h00, sel} + 9'h001) << LOCK_THR_SHIFT;
  endfunction

  // Ulimit = Ilim*Rph + speed*Kt, saturated to the amplitude range
  function automatic logic [8:0] amp_cap(input logic [3:0] sel,
    input logic [6:0] rm, input logic [9:0] spd, input logic [6:0] kt);
    logic [17:0] full;
    logic [17:0] scaled;
    full = 18'({5'h00, sel} + 5'h01) * 18'(rm) + 18'(spd) * 18'(kt);
    scaled = full >> AMP_SHIFT;
    if (scaled > 18'(AMP_MAX))
      amp_cap = AMP_MAX;
    else
      amp_cap = scaled[8:0];
  endfunction

  // mode-1 dividend: setting times the margin of amplitude over bemf
  always_comb
  begin
    logic [8:0] margin;
    margin = '0;
    if (s.drive > I_BEMF_AMP)
      margin = s.drive - I_BEMF_AMP;
    div_num = 20'(adv_decode(s.adv_set)) * 20'(margin); // [RULE3]
  end

  // serial divider keeps the scaling off a single wide combinational path
  adv_scale_div #(
    .NUM_W(20),
    .DEN_W(9)
  ) u_div (
    .i_clk(I_REF_CLK),
    .i_nrst(I_NRST),
    .i_ce(I_CE),
    // drive may fall to zero after the start request; never divide by it
    .i_start(s.div_start && (s.drive != 9'h000)),
    .i_num(div_num),
    .i_den(s.drive),
    .o_busy(div_busy),
    .o_done(div_done),
    .o_quot(div_quot)
  );

  // next-state logic
  always_comb
  begin
    logic [5:0] detect;
    logic [5:0] en_detect;
    logic oc_rise;
    logic enter_lock;
    logic restart;
    logic next_hiz;
    logic [8:0] cap;
    logic [8:0] cmd;
    logic [IRQ_W-1:0] ev;
    logic rd_stat;
    detect = '0;
    en_detect = '0;
    oc_rise = 1'b0;
    enter_lock = 1'b0;
    restart = 1'b0;
    next_hiz = 1'b0;
    cap = '0;
    cmd = '0;
    ev = '0;
    rd_stat = 1'b0;
    next_s = s;

    // pin synchroniser, only the second stage is read below
    next_s.oc_meta = I_OC_PIN;
    next_s.oc_sync = s.oc_meta;

    // low-side current compare is lock scheme 0
    detect[0] = ({1'b0, I_LS_CURRENT} >= lock_thr(s.lock_sel)) &&
      (s.st == ST_RUN); // [RULE14]
    detect[5:1] = I_LOCK_DET;
    en_detect = detect & s.lock_en; // [RULE8]

    // fault state machine
    case (s.st)
      ST_RUN:
      begin
        if (|en_detect)
        begin
          enter_lock = 1'b1;
          next_s.locked = 1'b1; // [RULE9] [RULE14]
          next_s.timer = TIMER_W'(LOCK_OFF_CYC); // [RULE16]
          next_s.st = ST_LOCKOFF; // [RULE12]
        end
      end
      ST_LOCKOFF:
      begin
        // phases stay off until the lock-off count runs out
        if (s.timer <= TIMER_W'(1))
        begin
          next_s.timer = '0;
          restart = 1'b1;
          next_s.locked = 1'b0;
          next_s.st = ST_RUN; // [RULE13]
        end
        else
          next_s.timer = s.timer - TIMER_W'(1); // [RULE16]
      end
      default:
      begin
        next_s.st = ST_RUN;
      end
    endcase

    // cause flags: cleared at restart, a fresh detection still wins
    if (restart)
      next_s.fault = detect; // [RULE10]
    else
      next_s.fault = s.fault | detect; // [RULE10] [RULE11]

    // hard overcurrent path has no enable and no level register
    oc_rise = s.oc_sync && !s.hiz && (s.st == ST_RUN); // [RULE4]
    next_hiz = (next_s.st == ST_LOCKOFF) || s.oc_sync; // [RULE5] [RULE12]
    next_s.hiz = next_hiz;
    // anti-surge on each move into the off state
    next_s.anti_surge_process = next_hiz && !s.hiz; // [RULE12]

    // amplitude: command ignored while off, capped only in closed loop
    cap = amp_cap(s.accel_sel, s.rm, I_SPEED_HZ, s.kt);
    cmd = I_SPEED_CMD;
    if (I_CLOSED_LOOP && (cmd > cap))
      cmd = cap; // [RULE6] [RULE7]
    if (next_hiz)
      next_s.drive = '0; // [RULE5] [RULE17]
    else
      next_s.drive = cmd;

    // advance time; mode 1 refreshed after each divide
    next_s.div_start = 1'b0;
    if (!s.adv_mode)
      next_s.adv_units = adv_decode(s.adv_set); // [RULE3]
    else if (s.drive == 9'h000)
      next_s.adv_units = '0; // [RULE3]
    else
    begin
      if (div_done)
        next_s.adv_units = div_quot[10:0]; // [RULE3]
      if (!div_busy && !s.div_start && !div_done)
        next_s.div_start = 1'b1;
    end
    next_s.adv_cyc = 19'(s.adv_units) * 19'(ADV_STEP_CYC); // [RULE1]

    // register writes
    if (I_WR)
    begin
      if (I_ADDR == REG_CTRL)
      begin
        next_s.adv_set = I_WDATA[CTRL_ADV_LSB +: 7];
        next_s.adv_mode = I_WDATA[CTRL_MODE_BIT];
        next_s.accel_sel = I_WDATA[CTRL_ACCEL_LSB +: 4];
        next_s.lock_sel = I_WDATA[CTRL_LOCK_LSB +: 3]; // [RULE15]
        next_s.lock_en = I_WDATA[CTRL_EN_LSB +: 6]; // [RULE8]
      end
      else if (I_ADDR == REG_MOTOR)
      begin
        next_s.rm = I_WDATA[MOTOR_RM_LSB +: 7];
        next_s.kt = I_WDATA[MOTOR_KT_LSB +: 7];
      end
      else if (I_ADDR == REG_IRQ_MASK)
        next_s.irq_mask = I_WDATA[IRQ_W-1:0];
    end

    // register reads, unmapped addresses answer zero
    next_s.rdata = '0;
    if (I_RD)
    begin
      if (I_ADDR == REG_CTRL)
      begin
        next_s.rdata[CTRL_ADV_LSB +: 7] = s.adv_set;
        next_s.rdata[CTRL_MODE_BIT] = s.adv_mode;
        next_s.rdata[CTRL_ACCEL_LSB +: 4] = s.accel_sel;
        next_s.rdata[CTRL_LOCK_LSB +: 3] = s.lock_sel;
        next_s.rdata[CTRL_EN_LSB +: 6] = s.lock_en;
      end
      else if (I_ADDR == REG_MOTOR)
      begin
        next_s.rdata[MOTOR_RM_LSB +: 7] = s.rm;
        next_s.rdata[MOTOR_KT_LSB +: 7] = s.kt;
      end
      else if (I_ADDR == REG_STATUS)
      begin
        next_s.rdata[STAT_LOCKED_BIT] = s.locked; // [RULE9]
        next_s.rdata[STAT_OC_BIT] = s.oc_sync;
        next_s.rdata[STAT_HIZ_BIT] = s.hiz;
        next_s.rdata[STAT_FAULT_LSB +: 6] = s.fault; // [RULE10]
      end
      else if (I_ADDR == REG_IRQ_STAT)
      begin
        next_s.rdata[IRQ_W-1:0] = s.irq_stat;
        rd_stat = 1'b1;
      end
      else if (I_ADDR == REG_IRQ_MASK)
        next_s.rdata[IRQ_W-1:0] = s.irq_mask;
      else if (I_ADDR == REG_ADV)
        next_s.rdata[10:0] = s.adv_units;
    end

    // sticky events: read clears, a same-cycle event survives
    ev[IRQ_LOCK] = enter_lock;
    ev[IRQ_OC] = oc_rise;
    ev[IRQ_RESTART] = restart;
    if (rd_stat)
      next_s.irq_stat = ev;
    else
      next_s.irq_stat = s.irq_stat | ev;
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
  end

  // state register, frozen while clock enable is low
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_NRST)
    begin
      s <= '0;
      s.st <= ST_RUN;
      s.lock_en <= LOCK_EN_RST;
      s.irq_mask <= IRQ_MASK_RST;
    end
    else if (I_CE)
      s <= next_s;
  end

  // every output straight from the state register
  assign O_RDATA = s.rdata;
  assign O_DRIVE_AMP = s.drive;
  assign O_PHASE_HIZ = s.hiz;
  assign O_AVS_START = s.anti_surge_process;
  assign O_LOCKED = s.locked;
  assign O_FAULT_CAUSE = s.fault;
  assign O_ADV_CYCLES = s.adv_cyc;
  assign O_IRQ = s.irq;
endmodule

// [testbench/motor_winding_model.sv]
`timescale 1ns/10ps
module motor_winding_model (
  input wire logic i_clk, // system clock
  input wire logic [8:0] i_drive, // applied amplitude
  input wire logic i_hiz, // phases released
  input wire logic i_stall, // rotor held
  input wire logic i_short, // phase shorted
  output logic [7:0] o_ls_cur, // low-side current
  output logic o_oc, // overcurrent comparator
  output logic [8:0] o_bemf // bemf amplitude
);
  // released phases carry no current, so a short only trips while driven
  always_ff @(posedge i_clk)
  begin
    o_ls_cur <= i_hiz ? 8'h00 : (i_stall ? 8'hff : i_drive[8:1]);
    o_oc <= i_short && !i_hiz && (i_drive != 9'h000);
    o_bemf <= (i_hiz || i_stall) ? 9'h000 : (i_drive >> 2);
  end
endmodule

// [testbench/motor_ctrl_monitor.sv]
`timescale 1ns/10ps
module motor_ctrl_monitor #(
  parameter int LOCK_OFF_CYC = 20
)(
  input wire logic I_REF_CLK, // clock
  input wire logic I_NRST, // sync reset
  input wire logic I_CE, // clock enable
  input wire logic I_OC_PIN, // overcurrent pin
  input wire logic [5:1] I_LOCK_DET, // detectors
  input wire logic I_CLOSED_LOOP, // closed loop
  input wire logic [8:0] I_SPEED_CMD, // command
  input wire logic [8:0] O_DRIVE_AMP, // amplitude
  input wire logic O_PHASE_HIZ, // hi-z
  input wire logic O_AVS_START, // anti-surge
  input wire logic O_LOCKED, // locked flag
  input wire logic [5:0] O_FAULT_CAUSE, // causes
  input wire logic [18:0] O_ADV_CYCLES // advance
);
  int lk_cnt;
  // cycles spent locked, compared with the lock-off length
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_NRST || !O_LOCKED)
      lk_cnt <= 0;
    else if (I_CE)
      lk_cnt <= lk_cnt + 1;
  end
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);
  avs_on_hiz_a: assert property ($rose(O_PHASE_HIZ) |-> O_AVS_START)
    else $error("no anti-surge pulse on hi-z entry");
  avs_single_a: assert property (O_AVS_START && I_CE |=> !O_AVS_START)
    else $error("anti-surge pulse too long");
  hiz_no_drive_a: assert property (O_PHASE_HIZ |-> O_DRIVE_AMP == 9'h000)
    else $error("drive while hi-z");
  locked_hiz_a: assert property (O_LOCKED |-> O_PHASE_HIZ)
    else $error("locked but phases driven");
  oc_trip_a: assert property ((I_CE && I_OC_PIN) [*3] |=> O_PHASE_HIZ)
    else $error("overcurrent did not stop drive");
  oc_resume_a: assert property (
    (I_CE && !I_OC_PIN) [*3] ##1 !O_LOCKED |-> !O_PHASE_HIZ)
    else $error("drive not resumed after overcurrent");
  cause_set_a: assert property (I_CE && I_LOCK_DET != 5'h00 |=>
    (O_FAULT_CAUSE[5:1] & $past(I_LOCK_DET)) == $past(I_LOCK_DET))
    else $error("cause flag missing");
  lockoff_len_a: assert property (
    $fell(O_LOCKED) && $past(I_NRST) |-> lk_cnt == LOCK_OFF_CYC)
    else $error("lock-off length wrong");
  open_loop_a: assert property (I_CE && !I_CLOSED_LOOP |=>
    O_PHASE_HIZ || O_DRIVE_AMP == $past(I_SPEED_CMD))
    else $error("open loop drive not the command");
  drive_cap_a: assert property (I_CE && I_CLOSED_LOOP |=>
    O_DRIVE_AMP <= $past(I_SPEED_CMD))
    else $error("drive above command");
  adv_grain_a: assert property (O_ADV_CYCLES % 19'd250 == 19'd0)
    else $error("advance not whole steps");
  lock_c: cover property ($rose(O_LOCKED));
  oc_c: cover property ($rose(O_PHASE_HIZ) && !O_LOCKED);
  restart_c: cover property ($fell(O_LOCKED));
endmodule
bind motor_advance_limit_lock_ctrl motor_ctrl_monitor #(
  .LOCK_OFF_CYC(LOCK_OFF_CYC)
) mon_u (.I_REF_CLK, .I_NRST, .I_CE, .I_OC_PIN, .I_LOCK_DET, .I_CLOSED_LOOP,
  .I_SPEED_CMD, .O_DRIVE_AMP, .O_PHASE_HIZ, .O_AVS_START, .O_LOCKED,
  .O_FAULT_CAUSE, .O_ADV_CYCLES);

// [testbench/motor_advance_limit_lock_ctrl_tb_top.sv]
`timescale 1ns/10ps
module motor_advance_limit_lock_ctrl_tb_top;
  import motor_ctrl_pkg::*;
  localparam int LOFF = 20;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic cl = 1'b0;
  logic stall = 1'b0;
  logic shrt = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [5:1] det = 5'h00;
  logic [8:0] cmd = 9'h000;
  logic [9:0] hz = 10'h0a0;
  logic [7:0] ls;
  logic oc, hiz, anti_surge_process, lck, irq;
  logic [8:0] drv, bemf;
  logic [5:0] cause;
  logic [18:0] advc;
  logic [31:0] rdata;
  int n_errors = 0;
  int checks_done = 0;
  initial
  begin
    forever #5 clk = ~clk;
  end
  motor_advance_limit_lock_ctrl #(.LOCK_OFF_CYC(LOFF)) dut_u (
    .I_REF_CLK(clk), .I_NRST(nrst), .I_CE(1'b1), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_OC_PIN(oc),
    .I_LS_CURRENT(ls), .I_LOCK_DET(det), .I_CLOSED_LOOP(cl),
    .I_SPEED_CMD(cmd), .I_SPEED_HZ(hz), .I_BEMF_AMP(bemf),
    .O_RDATA(rdata), .O_DRIVE_AMP(drv), .O_PHASE_HIZ(hiz),
    .O_AVS_START(anti_surge_process), .O_LOCKED(lck), .O_FAULT_CAUSE(cause),
    .O_ADV_CYCLES(advc), .O_IRQ(irq));
  motor_winding_model mot_u (.i_clk(clk), .i_drive(drv), .i_hiz(hiz),
    .i_stall(stall), .i_short(shrt), .o_ls_cur(ls), .o_oc(oc),
    .o_bemf(bemf));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // bus tasks start on an edge, so strobes never repeat in one step
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [7:0] a,
    input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(n, rdata, e);
  endtask
  // bounded wait for the phase state, a hang ends the run
  task automatic wait_hiz(input logic v, input int lim);
    int k = 0;
    while (hiz !== v && k < lim)
    begin
      @(negedge clk);
      k++;
    end
    if (hiz !== v)
    begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  // lock sel 3 kept above accel sel 1 as software should
  function automatic logic [31:0] cfg(input int code, input int md,
    input logic [5:0] en);
    return (32'(en) << CTRL_EN_LSB) | (32'h3 << CTRL_LOCK_LSB)
      | (32'h1 << CTRL_ACCEL_LSB) | (32'(md) << CTRL_MODE_BIT) | 32'(code);
  endfunction
  initial
  begin
    automatic int codes[9] = '{0, 1, 15, 24, 42, 95, 109, 127, 0};
    int e;
    e = $urandom(32'hd610);
    codes[8] = $urandom_range(127);
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rchk("ctrl", REG_CTRL, 32'h3f000000);
    rchk("status", REG_STATUS, 32'h0);
    wreg(8'h3c, 32'hffffffff);
    rchk("unmapped", 8'h3c, 32'h0);
    // advance decode, mantissa shifted by exponent
    foreach (codes[i])
    begin
      e = (codes[i] & 15) << (codes[i] >> 4);
      wreg(REG_CTRL, cfg(codes[i], 0, 6'h3f));
      repeat (30) @(posedge clk);
      rchk("adv", REG_ADV, 32'(e));
      check("adv cycles", 32'(advc), 32'(e * 250));
    end
    @(posedge clk);
    cmd <= 9'd200;
    wreg(REG_CTRL, cfg(15, 1, 6'h3f));
    repeat (60) @(posedge clk);
    rchk("adv scaled", REG_ADV, 32'(15 * (200 - 50) / 200));
    // cap = ((1+1)*8 + 160*1) >> 4 = 11 in closed loop
    wreg(REG_MOTOR, 32'h0108);
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      cmd <= 9'($urandom_range(255));
      cl <= i[0];
      @(posedge clk);
      @(negedge clk);
      e = (cl && cmd > 11) ? 11 : int'(cmd);
      check("drive", 32'(drv), 32'(e));
      check("no fault", 32'({lck, hiz}), 32'h0);
    end
    @(posedge clk);
    cl <= 1'b0;
    cmd <= 9'd200;
    wreg(REG_IRQ_MASK, 32'h1);
    @(posedge clk);
    det <= 5'h02;
    @(posedge clk);
    det <= 5'h00;
    cmd <= 9'h1ff;
    @(negedge clk);
    check("lock entry", 32'({hiz, lck, anti_surge_process, cause}), 32'h1c4);
    repeat (3) @(negedge clk);
    check("irq", 32'({irq, drv}), 32'h200);
    rchk("irq stat", REG_IRQ_STAT, 32'h1);
    rchk("irq clear", REG_IRQ_STAT, 32'h0);
    check("irq low", 32'(irq), 32'h0);
    // safe command before restart: full scale trips the current lock
    @(posedge clk);
    cmd <= 9'd200;
    wait_hiz(1'b0, LOFF + 5);
    check("restart", 32'({lck, cause}), 32'h0);
    wreg(REG_CTRL, cfg(0, 0, 6'h37));
    @(posedge clk);
    det <= 5'h04;
    @(posedge clk);
    det <= 5'h00;
    repeat (2) @(negedge clk);
    check("disabled", 32'({lck, hiz, cause}), 32'h08);
    @(posedge clk);
    stall <= 1'b1;
    wait_hiz(1'b1, 10);
    check("current lock", 32'({lck, cause}), 32'h49);
    stall <= 1'b0;
    wait_hiz(1'b0, LOFF + 5);
    check("causes cleared", 32'(cause), 32'h0);
    wreg(REG_IRQ_MASK, 32'h2);
    wreg(REG_CTRL, cfg(0, 0, 6'h00));
    @(posedge clk);
    shrt <= 1'b1;
    wait_hiz(1'b1, 10);
    check("oc no lock", 32'({lck, irq}), 32'h1);
    @(posedge clk);
    shrt <= 1'b0;
    repeat (8) @(negedge clk);
    check("oc resume", 32'({hiz, drv}), 32'd200);
    // lock entry and restart of the current lock are still pending too
    rchk("oc stat", REG_IRQ_STAT, 32'h7);
    tally_and_finish();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
endmodule
